// >>> pmc_top.sv
// power mode sequencer, supply supervisor and clock controller
`timescale 1ns/1ps
`include "pmc_consts.svh"
module pmc_top #(
	parameter int VREF_SETTLE_NS = 3000 // reference settle time
) (
	input wire logic hclk, // 100 MHz clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write strobe
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // response, always okay
	input wire logic wfi_req, // cpu wait-for-interrupt pulse
	input wire logic wfe_req, // cpu wait-for-event pulse
	input wire logic irq_any, // any pending interrupt
	input wire logic ext_irq, // external interrupt pin
	input wire logic rtc_irq, // rtc wake interrupt
	input wire logic halt_wake, // peripheral halt wakeup
	input wire logic lp_event, // peripheral event
	input wire logic por_below, // powerup_powerdown_detect comparator pin
	input wire logic bor_below, // brownout comparator pin
	input wire logic vdd_ok18, // supply above 1.8 V pin
	input wire logic pvd_high, // detector: supply above level
	input wire logic hs_ext_osc, // external osc sample pin
	input wire logic [2:0] opt_bor_lvl, // option byte level
	input wire logic opt_bor_dis, // option byte disable
	output logic sys_rst_n, // device reset, active low
	output logic cpu_clk_en, // core clock gate
	output logic [7:0] per_clk_en, // peripheral gates
	output logic mem_clk_en, // flash/eeprom gate
	output logic rtc_clk_en, // rtc clock gate
	output logic sys_clk_en, // system clock gate
	output logic [1:0] sys_src, // system clock mux select
	output logic [2:0] sys_div, // prescaler, divide 2^n
	output logic [1:0] rtc_src, // rtc source
	output logic [1:0] lcd_src, // display source
	output logic reg_lowpower, // regulator low power mode
	output logic vref_on, // internal reference enable
	output logic bor_en, // brownout detector enable
	output logic [2:0] bor_lvl, // brownout threshold
	output logic pvd_en, // detector enable
	output logic [2:0] pvd_lvl, // detector level
	output logic pvd_irq, // detector interrupt
	output logic irq_mask // cpu interrupt mask
);
	// ----------------------------------------------------------------
	// timing counts
	// ----------------------------------------------------------------
	localparam int FAST_CYC =
		(`PMC_FAST_WAKE_NS * `PMC_CLK_MHZ + 999) / 1000;
	localparam int SLOW_CYC =
		((`PMC_FAST_WAKE_NS + VREF_SETTLE_NS) * `PMC_CLK_MHZ
		+ 999) / 1000;
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	pmc_pkg::pmc_mode_t mode_r; // power mode
	pmc_pkg::pmc_sw_t sw_r; // switch step
	logic [`PMC_CFG_W-1:0] cfg_r; // configuration
	logic [`PMC_GATE_W-1:0] gate_r; // software gates
	logic [4:0] s1_r, s2_r, s3_r; // pin synchronisers
	logic [4:0] flt_r; // agreed pin levels
	logic hse_prev_r; // last agreed osc level
	logic [15:0] css_cnt_r; // cycles since osc edge
	logic css_fail_r; // failure flag
	logic pvd_fall_r, pvd_rise_r; // detector flags
	logic opt_done_r; // option bytes loaded
	logic bor_dis_r; // brownout disabled for good
	logic [2:0] bor_lvl_r; // loaded threshold
	logic [15:0] wake_cnt_r; // wake settle counter
	logic [3:0] gap_r; // switch gap counter
	logic [7:0] a_addr_r; // data-phase address
	logic a_wr_r; // data-phase write
	logic a_rd_r; // data-phase read

	// synchronised pin levels
	logic por_l, bor_l, vok_l, pvd_l, hse_l;
	assign {hse_l, pvd_l, vok_l, bor_l, por_l} = flt_r;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// an access of any size at a given byte offset
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] off);
		hit = (a == off);
	endfunction

	// modes that run on the low power regulator
	function automatic logic lp_mode(input pmc_pkg::pmc_mode_t m);
		lp_mode = (m == pmc_pkg::PMC_LPRUN) ||
			(m == pmc_pkg::PMC_LPWAIT) ||
			(m == pmc_pkg::PMC_AHALT) || (m == pmc_pkg::PMC_HALT);
	endfunction

	logic bus_go; // address phase taken
	assign bus_go = hsel & hready & htrans[1];
	logic wr_cmd, wr_cfg, wr_gate, wr_flag; // write strobes
	assign wr_cmd = a_wr_r & hit(a_addr_r, `PMC_OFF_CMD);
	assign wr_cfg = a_wr_r & hit(a_addr_r, `PMC_OFF_CFG);
	assign wr_gate = a_wr_r & hit(a_addr_r, `PMC_OFF_GATE);
	assign wr_flag = a_wr_r & hit(a_addr_r, `PMC_OFF_FLAG);
	logic sys_rst; // supply reset condition
	// brownout counts only while its comparator is powered
	assign sys_rst = por_l | (bor_l & bor_en);

	// ----------------------------------------------------------------
	// pin synchronisers: three flops, taken when 2nd and 3rd agree
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r <= 5'h00;
			s2_r <= 5'h00;
			s3_r <= 5'h00;
			flt_r <= 5'h01; // assume supply low until seen
		end else begin
			s1_r <= {hs_ext_osc, pvd_high, vdd_ok18, bor_below,
				por_below};
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < 5; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					flt_r[i] <= s3_r[i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// bus slave: zero wait, data phase registered
	// ----------------------------------------------------------------
	// read data is captured at the address phase so it can come
	// straight from a flop; it reflects state at that edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_addr_r <= 8'h00;
			a_wr_r <= 1'b0;
			a_rd_r <= 1'b0;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			a_wr_r <= bus_go & hwrite;
			a_rd_r <= bus_go & ~hwrite;
			a_addr_r <= haddr[7:0];
			hrdata <= 32'h00000000; // unmapped reads zero
			if (bus_go & ~hwrite) begin
				unique case (1'b1)
				hit(haddr[7:0], `PMC_OFF_CFG): begin
					hrdata <= {14'h0000, cfg_r};
				end
				hit(haddr[7:0], `PMC_OFF_GATE): begin
					hrdata <= {22'h000000, gate_r};
				end
				hit(haddr[7:0], `PMC_OFF_STAT): begin
					hrdata <= {18'h00000, opt_done_r, bor_dis_r,
						bor_lvl_r, pvd_l, reg_lowpower, sw_r != 
						pmc_pkg::PMC_SW_IDLE, sys_src, 1'b0,
						mode_r};
				end
				hit(haddr[7:0], `PMC_OFF_FLAG): begin
					hrdata <= {29'h00000000, pvd_rise_r,
						pvd_fall_r, css_fail_r};
				end
				default: begin
					hrdata <= 32'h00000000;
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration and gate registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_r <= `PMC_CFG_RST;
			gate_r <= `PMC_GATE_RST;
		end else if (sys_rst) begin
			cfg_r <= `PMC_CFG_RST;
			gate_r <= `PMC_GATE_RST;
		end else begin
			if (wr_cfg) begin
				cfg_r <= hwdata[`PMC_CFG_W-1:0];
			end
			// with the monitor on, failure overrides any request for the external osc
			if (css_fail_r & cfg_r[`PMC_CFG_CSS] &
				cfg_r[`PMC_CFG_SRC] == `PMC_SRC_HSE) begin
				cfg_r[`PMC_CFG_SRC] <= `PMC_SRC_HSI;
			end
			if (wr_gate) begin
				gate_r <= hwdata[`PMC_GATE_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// option byte load and brownout setup
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opt_done_r <= 1'b0;
			bor_dis_r <= 1'b0;
			bor_lvl_r <= 3'h0; // lowest, 1.8 V, at power-on
		end else if (por_l) begin
			opt_done_r <= 1'b0;
			bor_dis_r <= 1'b0;
			bor_lvl_r <= 3'h0;
		end else if (vok_l & ~opt_done_r) begin
			opt_done_r <= 1'b1;
			bor_dis_r <= opt_bor_dis;
			bor_lvl_r <= opt_bor_lvl;
		end
	end

	// ----------------------------------------------------------------
	// clock failure monitor on the agreed osc level
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hse_prev_r <= 1'b0;
			css_cnt_r <= 16'h0000;
			css_fail_r <= 1'b0;
		end else begin
			hse_prev_r <= hse_l;
			if (~cfg_r[`PMC_CFG_CSS] | hse_l != hse_prev_r) begin
				css_cnt_r <= 16'h0000;
			end else if (css_cnt_r != `PMC_CSS_LIMIT) begin
				css_cnt_r <= css_cnt_r + 16'h0001;
			end
			// set wins over a software clear in the same cycle
			if (cfg_r[`PMC_CFG_CSS] &
				css_cnt_r == `PMC_CSS_LIMIT) begin
				css_fail_r <= 1'b1;
			end else if (wr_flag & hwdata[0]) begin
				css_fail_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// supply threshold detector flags
	// ----------------------------------------------------------------
	logic pvd_prev_r; // last agreed detector level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pvd_prev_r <= 1'b0;
			pvd_fall_r <= 1'b0;
			pvd_rise_r <= 1'b0;
			pvd_irq <= 1'b0;
		end else begin
			pvd_prev_r <= pvd_l;
			if (cfg_r[`PMC_CFG_PVDEN] & pvd_prev_r & ~pvd_l) begin
				pvd_fall_r <= 1'b1;
			end else if (wr_flag & hwdata[1]) begin
				pvd_fall_r <= 1'b0;
			end
			if (cfg_r[`PMC_CFG_PVDEN] & ~pvd_prev_r & pvd_l) begin
				pvd_rise_r <= 1'b1;
			end else if (wr_flag & hwdata[2]) begin
				pvd_rise_r <= 1'b0;
			end
			pvd_irq <= (pvd_fall_r & cfg_r[`PMC_CFG_PVDF]) |
				(pvd_rise_r & cfg_r[`PMC_CFG_PVDR]);
		end
	end

	// ----------------------------------------------------------------
	// glitch-free source switch: gate off, change mux, gate on
	// ----------------------------------------------------------------
	// apart from supply reset the mux only moves while the system clock is gated, so no
	// runt pulse reaches the core; cost is a few stalled cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_r <= pmc_pkg::PMC_SW_IDLE;
			gap_r <= 4'h0;
			sys_src <= `PMC_SRC_HSI;
			sys_div <= 3'h3;
			sys_clk_en <= 1'b1;
		end else if (sys_rst) begin
			// supply reset puts back the start clock at once; the core
			// is held in reset then, so a short pulse does no harm
			sw_r <= pmc_pkg::PMC_SW_IDLE;
			sys_src <= `PMC_SRC_HSI;
			sys_div <= 3'h3;
			sys_clk_en <= 1'b1;
		end else begin
			sys_div <= cfg_r[`PMC_CFG_DIV];
			unique case (sw_r)
			pmc_pkg::PMC_SW_IDLE: begin
				if (cfg_r[`PMC_CFG_SRC] != sys_src) begin
					sw_r <= pmc_pkg::PMC_SW_OFF;
					sys_clk_en <= 1'b0;
					gap_r <= `PMC_SW_GAP;
				end
			end
			pmc_pkg::PMC_SW_OFF: begin
				if (gap_r == 4'h0) begin
					sw_r <= pmc_pkg::PMC_SW_SET;
				end else begin
					gap_r <= gap_r - 4'h1;
				end
			end
			pmc_pkg::PMC_SW_SET: begin
				sys_src <= cfg_r[`PMC_CFG_SRC];
				gap_r <= `PMC_SW_GAP;
				sw_r <= pmc_pkg::PMC_SW_ON;
			end
			pmc_pkg::PMC_SW_ON: begin
				if (gap_r == 4'h0) begin
					sys_clk_en <= 1'b1;
					sw_r <= pmc_pkg::PMC_SW_IDLE;
				end else begin
					gap_r <= gap_r - 4'h1;
				end
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// power mode sequencer
	// ----------------------------------------------------------------
	logic slow_src; // a low speed source is running the core
	assign slow_src = sys_src[1];
	logic [2:0] cmd; // command written this cycle
	assign cmd = wr_cmd ? hwdata[2:0] : 3'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_r <= pmc_pkg::PMC_RUN;
			wake_cnt_r <= 16'h0000;
		end else if (sys_rst) begin
			mode_r <= pmc_pkg::PMC_RUN;
		end else begin
			unique case (mode_r)
			pmc_pkg::PMC_RUN: begin
				if (wfi_req | wfe_req) begin
					mode_r <= pmc_pkg::PMC_WAIT;
				end else if (cmd == `PMC_CMD_LPRUN & slow_src) begin
					mode_r <= pmc_pkg::PMC_LPRUN;
				end else if (cmd == `PMC_CMD_AHALT) begin
					mode_r <= pmc_pkg::PMC_AHALT;
				end else if (cmd == `PMC_CMD_HALT) begin
					mode_r <= pmc_pkg::PMC_HALT;
				end
			end
			pmc_pkg::PMC_WAIT: begin
				if (irq_any | ext_irq) begin
					mode_r <= pmc_pkg::PMC_RUN;
				end
			end
			pmc_pkg::PMC_LPRUN: begin
				// interrupts cannot end this mode
				if (wfe_req) begin
					mode_r <= pmc_pkg::PMC_LPWAIT;
				end else if (cmd == `PMC_CMD_RUN) begin
					mode_r <= pmc_pkg::PMC_RUN;
				end
			end
			pmc_pkg::PMC_LPWAIT: begin
				if (lp_event) begin
					mode_r <= pmc_pkg::PMC_LPRUN;
				end
			end
			pmc_pkg::PMC_AHALT, pmc_pkg::PMC_HALT: begin
				if (ext_irq | (mode_r == pmc_pkg::PMC_AHALT ?
					rtc_irq : halt_wake)) begin
					mode_r <= pmc_pkg::PMC_WAKE;
					wake_cnt_r <= 16'((cfg_r[`PMC_CFG_FAST] |
						~cfg_r[`PMC_CFG_VOFF]) ?
						FAST_CYC : SLOW_CYC);
				end
			end
			pmc_pkg::PMC_WAKE: begin
				if (wake_cnt_r <= 16'h0001) begin
					mode_r <= pmc_pkg::PMC_RUN;
				end else begin
					wake_cnt_r <= wake_cnt_r - 16'h0001;
				end
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// gates, regulator, reference and reset outputs
	// ----------------------------------------------------------------
	logic in_halt; // both halt modes, without the wake settle
	assign in_halt = mode_r == pmc_pkg::PMC_AHALT ||
		mode_r == pmc_pkg::PMC_HALT;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_clk_en <= 1'b1;
			per_clk_en <= 8'hff;
			mem_clk_en <= 1'b1;
			rtc_clk_en <= 1'b1;
			reg_lowpower <= 1'b0;
			vref_on <= 1'b1;
			bor_en <= 1'b1;
			sys_rst_n <= 1'b0;
			irq_mask <= 1'b0;
			rtc_src <= `PMC_SRC_HSI;
			lcd_src <= `PMC_SRC_HSI;
			bor_lvl <= 3'h0;
			pvd_en <= 1'b0;
			pvd_lvl <= 3'h0;
		end else begin
			// core stopped in wait, halt and settle
			cpu_clk_en <= gate_r[8] &
				(mode_r == pmc_pkg::PMC_RUN ||
				mode_r == pmc_pkg::PMC_LPRUN);
			per_clk_en <= in_halt | mode_r == pmc_pkg::PMC_WAKE ?
				8'h00 : gate_r[7:0];
			mem_clk_en <= gate_r[9] & ~lp_mode(mode_r) &
				mode_r != pmc_pkg::PMC_WAKE;
			rtc_clk_en <= mode_r != pmc_pkg::PMC_HALT;
			reg_lowpower <= lp_mode(mode_r);
			vref_on <= ~(in_halt & cfg_r[`PMC_CFG_VOFF]);
			bor_en <= ~bor_dis_r &
				~(in_halt & cfg_r[`PMC_CFG_VOFF]);
			sys_rst_n <= ~sys_rst;
			irq_mask <= mode_r == pmc_pkg::PMC_LPRUN ||
				mode_r == pmc_pkg::PMC_LPWAIT;
			rtc_src <= cfg_r[`PMC_CFG_RTC];
			lcd_src <= cfg_r[`PMC_CFG_LCD];
			bor_lvl <= bor_lvl_r;
			pvd_en <= cfg_r[`PMC_CFG_PVDEN];
			pvd_lvl <= cfg_r[`PMC_CFG_PVDLV];
		end
	end
endmodule

// >>> pmc_consts.svh
// constant definitions for the power mode and clock controller
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PMC_OFF_CFG 8'h00
`define PMC_OFF_CMD 8'h04
`define PMC_OFF_GATE 8'h08
`define PMC_OFF_STAT 8'h0c
`define PMC_OFF_FLAG 8'h10
// ----------------------------------------------------------------
// cfg fields
// ----------------------------------------------------------------
`define PMC_CFG_SRC 1:0
`define PMC_CFG_DIV 4:2
`define PMC_CFG_CSS 5
`define PMC_CFG_FAST 6
`define PMC_CFG_VOFF 7
`define PMC_CFG_PVDEN 8
`define PMC_CFG_PVDLV 11:9
`define PMC_CFG_PVDF 12
`define PMC_CFG_PVDR 13
`define PMC_CFG_RTC 15:14
`define PMC_CFG_LCD 17:16
`define PMC_CFG_W 18
// hs_int_rc divided by eight after reset
`define PMC_CFG_RST 18'h0000d
// ----------------------------------------------------------------
// commands, source codes, gate reset
// ----------------------------------------------------------------
`define PMC_CMD_LPRUN 3'h1
`define PMC_CMD_RUN 3'h2
`define PMC_CMD_AHALT 3'h3
`define PMC_CMD_HALT 3'h4
`define PMC_SRC_HSE 2'h0
`define PMC_SRC_HSI 2'h1
`define PMC_SRC_LSE 2'h2
`define PMC_SRC_LSI 2'h3
`define PMC_GATE_W 10
`define PMC_GATE_RST 10'h3ff
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PMC_CLK_MHZ 100
`define PMC_FAST_WAKE_NS 5000
`define PMC_CSS_LIMIT 16'd64
`define PMC_SW_GAP 4'd2
`endif

// >>> pmc_pkg.sv
// types shared by the power mode and clock controller
package pmc_pkg;
	// power modes of the device
	typedef enum logic [2:0] {
		PMC_RUN, PMC_WAIT, PMC_LPRUN, PMC_LPWAIT,
		PMC_AHALT, PMC_HALT, PMC_WAKE
	} pmc_mode_t;
	// glitch-free source switch steps
	typedef enum logic [1:0] {
		PMC_SW_IDLE, PMC_SW_OFF, PMC_SW_SET, PMC_SW_ON
	} pmc_sw_t;
endpackage

// >>> pmc_check_sva.sv
// checker: port-level properties of the power mode and clock controller
`timescale 1ns/1ps
module pmc_check (
	input wire logic hclk, // bus clock
	input wire logic hresetn, // async reset, low
	input wire logic [1:0] htrans, // bus transfer type
	input wire logic hreadyout, // slave ready
	input wire logic hresp, // slave response
	input wire logic irq_any, // pending interrupt
	input wire logic ext_irq, // external interrupt
	input wire logic sys_rst_n, // device reset, low
	input wire logic cpu_clk_en, // core gate
	input wire logic [7:0] per_clk_en, // peripheral gates
	input wire logic mem_clk_en, // memory gate
	input wire logic sys_clk_en, // system gate
	input wire logic [1:0] sys_src, // system mux select
	input wire logic [2:0] sys_div, // prescaler
	input wire logic reg_lowpower, // regulator low power
	input wire logic vref_on, // reference enable
	input wire logic bor_en, // brownout enable
	input wire logic irq_mask // interrupt mask
);
	// ----------------------------------------------------------------
	// one clock domain: shared clocking and reset
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	property p_bus_ok;
		hreadyout && !hresp;
	endproperty
	a_bus_ok: assert property (p_bus_ok) else $error("bus stall or error");
	// two cycles of supply reset are enough to restore the start clock
	property p_rst_cfg;
		!sys_rst_n [*2] |-> sys_src == 2'h1 && sys_div == 3'h3;
	endproperty
	a_rst_cfg: assert property (p_rst_cfg) else $error("start clock lost");
	// the mux may only move while the system clock is gated
	property p_sw_gate;
		disable iff (!hresetn || !sys_rst_n)
		$changed(sys_src) |-> !sys_clk_en;
	endproperty
	a_sw_gate: assert property (p_sw_gate) else $error("mux moved ungated");
	property p_sw_len;
		disable iff (!hresetn || !sys_rst_n)
		$fell(sys_clk_en) |=> !sys_clk_en [*3];
	endproperty
	a_sw_len: assert property (p_sw_len) else $error("gate gap too short");
	// running on the low power regulator means slow clock, masked irqs
	property p_lp_run;
		disable iff (!hresetn || !sys_rst_n)
		reg_lowpower && cpu_clk_en |-> sys_src[1] && irq_mask && !mem_clk_en;
	endproperty
	a_lp_run: assert property (p_lp_run) else $error("bad low power run");
	property p_halt_lp;
		!cpu_clk_en && per_clk_en == 8'h00 && $past(per_clk_en) != 8'h00
			|-> reg_lowpower;
	endproperty
	a_halt_lp: assert property (p_halt_lp) else $error("halt on main reg");
	property p_vref;
		!vref_on |-> !bor_en && !cpu_clk_en;
	endproperty
	a_vref: assert property (p_vref) else $error("reference off badly");
	// no bus write pending, so only an interrupt could clear the mask
	property p_mask;
		disable iff (!hresetn || !sys_rst_n)
		irq_mask && (irq_any || ext_irq) && !htrans[1] && !$past(htrans[1])
			&& !$past(htrans[1], 2) |=> irq_mask;
	endproperty
	a_mask: assert property (p_mask) else $error("irq left low power");
endmodule
bind pmc_top pmc_check u_chk (
	.hclk(hclk), .hresetn(hresetn), .htrans(htrans),
	.hreadyout(hreadyout), .hresp(hresp), .irq_any(irq_any),
	.ext_irq(ext_irq), .sys_rst_n(sys_rst_n), .cpu_clk_en(cpu_clk_en),
	.per_clk_en(per_clk_en), .mem_clk_en(mem_clk_en),
	.sys_clk_en(sys_clk_en), .sys_src(sys_src), .sys_div(sys_div),
	.reg_lowpower(reg_lowpower), .vref_on(vref_on), .bor_en(bor_en),
	.irq_mask(irq_mask)
);

// >>> pmc_far_model.sv
// far side model: external crystal and option byte store
`timescale 1ns/1ps
module pmc_far_model #(
	parameter logic [2:0] OPT_LVL = 3'h4 // stored brownout level
) (
	input wire logic hclk, // reference for the crystal rate
	input wire logic osc_run, // crystal alive
	output logic hs_ext_osc, // crystal output
	output logic [2:0] opt_bor_lvl, // option byte level
	output logic opt_bor_dis // option byte disable
);
	logic [2:0] div_r = 3'h0; // keeps edges slower than the pin filter
	assign hs_ext_osc = div_r[2];
	// a dead crystal holds its level, so only missing edges reveal it
	always @(posedge hclk) begin
		if (osc_run) begin
			div_r <= div_r + 3'h1;
		end
	end
	assign opt_bor_lvl = OPT_LVL;
	assign opt_bor_dis = 1'b0;
endmodule

// >>> pmc_top_bench.sv
// self-checking bench for the power mode and clock controller
`timescale 1ns/1ps
`include "pmc_consts.svh"
module pmc_top_bench;
	logic hclk, hresetn, hwrite, hreadyout, hresp, wfi_req, wfe_req;
	logic irq_any, ext_irq, rtc_irq, halt_wake, lp_event, por_below;
	logic bor_below, vdd_ok18, pvd_high, osc_run, hs_ext_osc, opt_bor_dis;
	logic sys_rst_n, cpu_clk_en, mem_clk_en, rtc_clk_en, sys_clk_en;
	logic reg_lowpower, vref_on, bor_en, pvd_en, pvd_irq, irq_mask;
	logic [1:0] htrans, sys_src, rtc_src, lcd_src;
	logic [2:0] sys_div, bor_lvl, pvd_lvl, opt_bor_lvl;
	logic [7:0] per_clk_en;
	logic [31:0] haddr, hwdata, hrdata, q;
	int err_count, n_compared, n;
	// slow settle so fast and slow wakeups differ
	pmc_top #(.VREF_SETTLE_NS(10000)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .wfi_req(wfi_req), .wfe_req(wfe_req),
		.irq_any(irq_any), .ext_irq(ext_irq), .rtc_irq(rtc_irq),
		.halt_wake(halt_wake), .lp_event(lp_event), .por_below(por_below),
		.bor_below(bor_below), .vdd_ok18(vdd_ok18), .pvd_high(pvd_high),
		.hs_ext_osc(hs_ext_osc), .opt_bor_lvl(opt_bor_lvl),
		.opt_bor_dis(opt_bor_dis), .sys_rst_n(sys_rst_n),
		.cpu_clk_en(cpu_clk_en), .per_clk_en(per_clk_en),
		.mem_clk_en(mem_clk_en), .rtc_clk_en(rtc_clk_en),
		.sys_clk_en(sys_clk_en), .sys_src(sys_src), .sys_div(sys_div),
		.rtc_src(rtc_src), .lcd_src(lcd_src), .reg_lowpower(reg_lowpower),
		.vref_on(vref_on), .bor_en(bor_en), .bor_lvl(bor_lvl),
		.pvd_en(pvd_en), .pvd_lvl(pvd_lvl), .pvd_irq(pvd_irq),
		.irq_mask(irq_mask)
	);
	pmc_far_model #(.OPT_LVL(3'h4)) u_far (
		.hclk(hclk), .osc_run(osc_run), .hs_ext_osc(hs_ext_osc),
		.opt_bor_lvl(opt_bor_lvl), .opt_bor_dis(opt_bor_dis)
	);
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic tick(input int k);
		repeat (k) @(posedge hclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	// one single transfer; read data lands in q at the data phase edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wait_src(input logic [1:0] s);
		for (n = 0; n < 60 && sys_src !== s; n++) @(posedge hclk);
	endtask
	task automatic mode_is(input logic [2:0] m);
		bus(1'b0, `PMC_OFF_STAT, 32'h0);
		chk("mode", m, q[2:0]);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_boot;
		for (n = 0; n < 30 && sys_rst_n !== 1'b1; n++) @(posedge hclk);
		tick(4);
		chk("sys_rst_n", 1, sys_rst_n);
		bus(1'b0, `PMC_OFF_CFG, 32'h0);
		chk("cfg", 32'h0000d, q);
		chk("sys_div", 3'h3, sys_div);
		bus(1'b0, `PMC_OFF_GATE, 32'h0);
		chk("gate", 32'h3ff, q);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(1'b0, `PMC_OFF_STAT, 32'h0);
		chk("options", 5'h14, q[13:9]);
		chk("bor_lvl", 3'h4, bor_lvl);
	endtask
	// every source with its own divider, rtc and display sources apart
	task automatic t_switch;
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, `PMC_OFF_CFG, {14'h0, 2'(s), 2'(3 - s), 9'h0, 3'(s),
				2'(s)});
			wait_src(2'(s));
			chk("sys_src", s, sys_src);
			chk("sys_div", s, sys_div);
			chk("rtc_src", 3 - s, rtc_src);
			chk("lcd_src", s, lcd_src);
		end
	endtask
	task automatic t_lprun;
		bus(1'b1, `PMC_OFF_CMD, `PMC_CMD_LPRUN);
		tick(3);
		mode_is(3'h2);
		chk("mem_clk_en", 0, mem_clk_en);
		chk("irq_mask", 1, irq_mask);
		{irq_any, ext_irq} <= 2'h3;
		tick(3);
		{irq_any, ext_irq} <= 2'h0;
		mode_is(3'h2);
		wfe_req <= 1'b1;
		tick(1);
		wfe_req <= 1'b0;
		tick(3);
		mode_is(3'h3);
		chk("cpu_clk_en", 0, cpu_clk_en);
		lp_event <= 1'b1;
		tick(1);
		lp_event <= 1'b0;
		tick(3);
		mode_is(3'h2);
		bus(1'b1, `PMC_OFF_CMD, `PMC_CMD_RUN);
		tick(3);
		mode_is(3'h0);
		chk("reg_lowpower", 0, reg_lowpower);
		// entry must be refused while a fast source drives the system
		bus(1'b1, `PMC_OFF_CFG, 32'h0000d);
		wait_src(2'h1);
		bus(1'b1, `PMC_OFF_CMD, `PMC_CMD_LPRUN);
		tick(3);
		mode_is(3'h0);
	endtask
	task automatic t_wait;
		wfi_req <= 1'b1;
		tick(1);
		wfi_req <= 1'b0;
		tick(3);
		chk("cpu_clk_en", 0, cpu_clk_en);
		chk("per_clk_en", 8'hff, per_clk_en);
		irq_any <= 1'b1;
		tick(1);
		irq_any <= 1'b0;
		for (n = 0; n < 20 && cpu_clk_en !== 1'b1; n++) @(posedge hclk);
		chk("cpu_clk_en", 1, cpu_clk_en);
	endtask
	// enter a halt kind, check the gates, wake by source w, time it
	task automatic halt_once(input logic [31:0] cfg, input logic [2:0] cmd,
		input int w, input logic vref_exp);
		bus(1'b1, `PMC_OFF_CFG, cfg);
		bus(1'b1, `PMC_OFF_CMD, {29'h0, cmd});
		tick(3);
		chk("per_clk_en", 8'h00, per_clk_en);
		chk("reg_lowpower", 1, reg_lowpower);
		chk("vref_on", vref_exp, vref_on);
		chk("bor_en", vref_exp, bor_en);
		if (cmd == `PMC_CMD_AHALT) chk("rtc_clk_en", 1, rtc_clk_en);
		rtc_irq <= (w == 0);
		halt_wake <= (w == 1);
		ext_irq <= (w == 2);
		tick(1);
		{rtc_irq, halt_wake, ext_irq} <= 3'h0;
		for (n = 0; n < 2000 && cpu_clk_en !== 1'b1; n++) @(posedge hclk);
	endtask
	task automatic t_halt;
		halt_once(32'h0000d, `PMC_CMD_AHALT, 0, 1'b1);
		chk("rtc wake", 1, n < 600);
		halt_once(32'h000cd, `PMC_CMD_HALT, 1, 1'b0);
		chk("fast wake", 1, n < 600);
		halt_once(32'h0008d, `PMC_CMD_HALT, 2, 1'b0);
		chk("slow wake", 1, n > 600 && n < 2000);
	endtask
	task automatic t_pvd;
		bus(1'b1, `PMC_OFF_CFG, 32'h03b0d);
		tick(8);
		bus(1'b1, `PMC_OFF_FLAG, 32'h7);
		chk("pvd_lvl", 3'h5, pvd_lvl);
		chk("pvd_en", 1, pvd_en);
		pvd_high <= 1'b1;
		tick(10);
		chk("pvd_irq", 1, pvd_irq);
		bus(1'b1, `PMC_OFF_FLAG, 32'h7);
		pvd_high <= 1'b0;
		tick(10);
		bus(1'b0, `PMC_OFF_FLAG, 32'h0);
		chk("fall only", 2'h1, q[2:1]);
	endtask
	task automatic t_css;
		bus(1'b1, `PMC_OFF_CFG, 32'h00020);
		wait_src(2'h0);
		osc_run <= 1'b0;
		tick(40);
		chk("early fallback", 2'h0, sys_src);
		for (n = 0; n < 200 && sys_src !== 2'h1; n++) @(posedge hclk);
		chk("fallback", 2'h1, sys_src);
		osc_run <= 1'b1;
		tick(8);
		bus(1'b0, `PMC_OFF_FLAG, 32'h0);
		chk("fail flag", 1, q[0]);
	endtask
	// each supply comparator holds reset and restores the start clock
	task automatic t_supply;
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, `PMC_OFF_CFG, 32'h0000f);
			wait_src(2'h3);
			bor_below <= (i == 0);
			por_below <= (i == 1);
			tick(8);
			chk("held reset", 0, sys_rst_n);
			bor_below <= 1'b0;
			por_below <= 1'b0;
			for (n = 0; n < 40 && sys_rst_n !== 1'b1; n++) @(posedge hclk);
			bus(1'b0, `PMC_OFF_CFG, 32'h0);
			chk("cfg", 32'h0000d, q);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// the whole run is a few thousand cycles; this cuts a hang short
	initial begin
		#500000;
		err_count++;
		tally_and_finish;
	end
	initial begin
		{hresetn, hwrite, wfi_req, wfe_req, irq_any, ext_irq} = 6'h0;
		{rtc_irq, halt_wake, lp_event, por_below, bor_below} = 5'h0;
		{pvd_high, htrans, haddr, hwdata} = 67'h0;
		vdd_ok18 = 1'b1;
		osc_run = 1'b1;
		err_count = 0;
		n_compared = 0;
		tick(2);
		hresetn <= 1'b1;
		t_boot;
		t_switch;
		t_lprun;
		t_wait;
		t_halt;
		t_pvd;
		t_css;
		t_supply;
		tally_and_finish;
	end
endmodule
